// ===== sscr_defs.vh
// Constants for the switching-status frame reporter.
// Assumes inclusion by the reporter and its FIFO; holds definitions only.
`ifndef SSCR_DEFS_VH
`define SSCR_DEFS_VH
`define SSCR_CLK_MHZ 125
`define SSCR_RESP_MAX_MS 100
`define SSCR_RESP_MAX_CYC (`SSCR_RESP_MAX_MS * 1000 * `SSCR_CLK_MHZ)
`define SSCR_PRIO 3'h6
`define SSCR_DATA_PAGE 1'h0
`define SSCR_PDU_FMT 8'hff
`define SSCR_PDU_SPEC 8'h0f
`define SSCR_PGN 18'h0_ff0f
`define SSCR_NIB_OFF 4'h0
`define SSCR_NIB_ON 4'h1
`define SSCR_UNUSED_BYTE 8'h00
`define SSCR_DLC 4'h8
`define SSCR_NCH 12
`define SSCR_FIFO_W 8
`define SSCR_FIFO_D 4
`define SSCR_FIFO_AW 2
`endif

// ===== sscr_fifo.v
// Small synchronous FIFO carrying payload bytes to the frame output.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "sscr_defs.vh"
module sscr_fifo #(
    parameter W = 8,
    parameter D = 4,
    parameter AW = 2
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    // Full and empty come straight from the occupancy count.
    assign o_in_ready = (cnt_r != D[AW:0]);
    assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
    assign o_out_data = mem[rp_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage needs no reset; only pointers and count define state.
    always @(posedge i_clk) begin
        if (push) begin
            mem[wp_r] <= i_in_data;
        end
    end

    // Pointers wrap naturally since depth is a power of two.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // sscr_fifo

// ===== sscr_reporter.v
// Switching-status frame builder: answers a request for its parameter group
// with one 29-bit-identifier frame of eight data bytes, streamed bytewise.
// Assumes a CAN controller that decodes requests into i_req_pgn/i_req_valid
// and takes the frame header on an o_frm_start pulse and the bytes through a valid/ready handshake.
// Channel states arrive from pins and are synchronised here.
`timescale 1ns/100ps
`include "sscr_defs.vh"
module sscr_reporter #(
    parameter RESP_MAX_CYC = `SSCR_RESP_MAX_CYC
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] i_node_addr,
    input wire [11:0] i_ch_on,
    input wire i_req_valid,
    input wire [17:0] i_req_pgn,
    output reg o_frm_start,
    output reg [28:0] o_frm_id,
    output reg [3:0] o_frm_dlc,
    output reg o_byte_valid,
    output reg [7:0] o_byte_data,
    output reg o_byte_last,
    input wire i_byte_ready,
    output reg o_busy,
    output reg o_late
);
    localparam ST_IDLE = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_SEND = 2'd2;

    reg [11:0] ch_s1_r;
    reg [11:0] ch_s2_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [63:0] snap_r;
    reg [3:0] ld_cnt_r;
    reg [3:0] tx_cnt_r;
    reg [31:0] age_r;
    wire [63:0] payload;
    wire req_hit;
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire f_in_valid;
    wire f_out_ready;

    // Two-flop synchroniser for the channel state pins.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ch_s1_r <= 12'h000;
            ch_s2_r <= 12'h000;
        end else begin
            ch_s1_r <= i_ch_on;
            ch_s2_r <= ch_s1_r;
        end
    end

    // Pack channel pairs; byte 1 sits in the top bits so it goes out first.
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_pair
            assign payload[63-8*g -: 4] = ch_s2_r[2*g] ? `SSCR_NIB_ON : `SSCR_NIB_OFF;
            assign payload[59-8*g -: 4] = ch_s2_r[2*g+1] ? `SSCR_NIB_ON : `SSCR_NIB_OFF;
        end
    endgenerate
    assign payload[15:0] = {`SSCR_UNUSED_BYTE, `SSCR_UNUSED_BYTE};

    // Only a request naming our group starts a frame; requests while busy are dropped.
    assign req_hit = i_req_valid && (i_req_pgn == `SSCR_PGN);

    // Frame sequencer next state.
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (req_hit) begin
                    st_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (ld_cnt_r == 4'd7 && f_in_ready) begin
                    st_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (o_byte_valid && i_byte_ready && o_byte_last) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // The snapshot freezes channel states so the frame is self-consistent.
    assign f_in_valid = (st_r == ST_LOAD);
    // Drain already while loading: eight bytes cannot wait in a four-deep buffer.
    assign f_out_ready = (st_r == ST_LOAD || st_r == ST_SEND) && (!o_byte_valid || i_byte_ready);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            snap_r <= 64'h0000_0000_0000_0000;
            ld_cnt_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            age_r <= 32'h0000_0000;
            o_frm_start <= 1'b0;
            o_frm_id <= 29'h0000_0000;
            o_frm_dlc <= 4'h0;
            o_byte_valid <= 1'b0;
            o_byte_data <= 8'h00;
            o_byte_last <= 1'b0;
            o_busy <= 1'b0;
            o_late <= 1'b0;
        end else begin
            st_r <= st_nxt;
            o_frm_start <= 1'b0;
            o_busy <= (st_nxt != ST_IDLE);
            if (st_r == ST_IDLE && req_hit) begin
                snap_r <= payload;
                ld_cnt_r <= 4'h0;
                tx_cnt_r <= 4'h0;
                age_r <= 32'h0000_0000;
                o_late <= 1'b0;
                o_frm_start <= 1'b1;
                o_frm_id <= {`SSCR_PRIO, 1'b0, `SSCR_DATA_PAGE, `SSCR_PDU_FMT, `SSCR_PDU_SPEC, i_node_addr};
                o_frm_dlc <= `SSCR_DLC;
            end
            if (st_r == ST_LOAD && f_in_ready) begin
                snap_r <= {snap_r[55:0], 8'h00};
                ld_cnt_r <= ld_cnt_r + 4'd1;
            end
            // Response age; flag if the partner stalls past the deadline.
            if (st_r != ST_IDLE) begin
                age_r <= age_r + 32'd1;
                if (age_r == RESP_MAX_CYC[31:0]) begin
                    o_late <= 1'b1;
                end
            end
            // Output byte register with skid-free handshake.
            if (f_out_ready) begin
                o_byte_valid <= f_out_valid;
                if (f_out_valid) begin
                    o_byte_data <= f_out_data;
                    o_byte_last <= (tx_cnt_r == 4'd7);
                    tx_cnt_r <= tx_cnt_r + 4'd1;
                end
            end else if (o_byte_valid && i_byte_ready) begin
                o_byte_valid <= 1'b0;
                o_byte_last <= 1'b0;
            end
        end
    end

    // The FIFO decouples byte generation from controller stalls.
    sscr_fifo #(
        .W(`SSCR_FIFO_W),
        .D(`SSCR_FIFO_D),
        .AW(`SSCR_FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(f_in_valid),
        .o_in_ready(f_in_ready),
        .i_in_data(snap_r[63:56]),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_out_ready),
        .o_out_data(f_out_data)
    );
endmodule // sscr_reporter

// ===== sscr_reporter_chk.sv
// Port checks for the status frame reporter, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module sscr_reporter_chk (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] i_node_addr,
    input wire [11:0] i_ch_on,
    input wire i_req_valid,
    input wire [17:0] i_req_pgn,
    input wire o_frm_start,
    input wire [28:0] o_frm_id,
    input wire [3:0] o_frm_dlc,
    input wire o_byte_valid,
    input wire [7:0] o_byte_data,
    input wire o_byte_last,
    input wire i_byte_ready,
    input wire o_busy,
    input wire o_late
);
    // One clock domain, so every check shares clock and reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire req_ok = i_req_valid && i_req_pgn == 18'h0_ff0f;
    a_no_spont_start: assert property (o_frm_start |-> $past(req_ok)) else $error("start without request");
    a_start_on_req: assert property (req_ok && !o_busy && !$past(o_busy) |=> o_frm_start)
        else $error("request not taken");
    a_id_value: assert property (o_frm_start |-> o_frm_id == {21'h18_ff0f, i_node_addr})
        else $error("bad identifier");
    a_dlc_eight: assert property (o_frm_start |-> o_frm_dlc == 4'h8) else $error("bad length");
    a_first_byte: assert property (o_frm_start |-> ##[1:4] o_byte_valid) else $error("first byte late");
    a_byte_hold: assert property (o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte_data))
        else $error("byte dropped while stalled");
    a_nibble_code: assert property (o_byte_valid |-> o_byte_data[7:5] == 3'h0 && o_byte_data[3:1] == 3'h0)
        else $error("bad nibble code");
    a_tail_zero: assert property (o_byte_valid && o_byte_last |-> o_byte_data == 8'h00)
        else $error("tail byte not zero");
    a_late_busy: assert property ($rose(o_late) |-> $past(o_busy)) else $error("late flag when idle");
endmodule // sscr_reporter_chk
bind sscr_reporter sscr_reporter_chk sscr_reporter_chk_i (.i_clk, .i_rst_n, .i_node_addr, .i_ch_on, .i_req_valid,
    .i_req_pgn, .o_frm_start, .o_frm_id, .o_frm_dlc, .o_byte_valid, .o_byte_data, .o_byte_last, .i_byte_ready,
    .o_busy, .o_late);

// ===== sscr_can_sink.sv
// Model of the controller side that takes the frame bytes.
// Assumes the bench picks the pacing mode.
`timescale 1ns/100ps
module sscr_can_sink (
    input wire i_clk,
    input wire i_rst_n,
    input wire [1:0] i_mode,
    input wire i_byte_valid,
    input wire [7:0] i_byte_data,
    output reg o_byte_ready,
    output reg [63:0] o_frame
);
    // Mode 0 takes every byte, 1 every other cycle, 2 stalls so the buffer fills.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_byte_ready <= 1'b0;
        end else begin
            o_byte_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && !o_byte_ready);
        end
        if (i_rst_n && i_byte_valid && o_byte_ready) begin
            o_frame <= {o_frame[55:0], i_byte_data};
        end
    end
endmodule // sscr_can_sink

// ===== sscr_reporter_bench.sv
// Self-checking bench for the status frame reporter.
// Assumes the sink model paces the byte stream.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module sscr_reporter_bench;
    logic i_clk = 0, i_rst_n = 0, i_req_valid = 0;
    logic [7:0] i_node_addr = 8'h00;
    logic [11:0] i_ch_on = 12'h000;
    logic [17:0] i_req_pgn = 18'h0_0000;
    logic [1:0] mode = 2'h0;
    wire o_frm_start, o_byte_valid, o_byte_last, i_byte_ready, o_busy, o_late;
    wire [28:0] o_frm_id;
    wire [3:0] o_frm_dlc;
    wire [7:0] o_byte_data;
    wire [63:0] frame;
    int n_errors = 0, n_checks = 0, n_starts = 0, i, s;
    sscr_reporter #(.RESP_MAX_CYC(50)) sscr_reporter_i (.i_clk, .i_rst_n, .i_node_addr, .i_ch_on, .i_req_valid,
        .i_req_pgn, .o_frm_start, .o_frm_id, .o_frm_dlc, .o_byte_valid, .o_byte_data, .o_byte_last,
        .i_byte_ready, .o_busy, .o_late);
    sscr_can_sink sscr_can_sink_i (.i_clk, .i_rst_n, .i_mode(mode), .i_byte_valid(o_byte_valid),
        .i_byte_data(o_byte_data), .o_byte_ready(i_byte_ready), .o_frame(frame));
    // Free-running 8 ns clock.
    initial forever #4 i_clk = ~i_clk;
    // Count accepted frames so dropped requests show up.
    always @(posedge i_clk) if (o_frm_start === 1'b1) n_starts++;
    task test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Bounded wait, so a stuck frame ends the run instead of hanging it.
    task wait_idle;
        for (i = 0; i < 300 && o_busy !== 1'b0; i++) @(negedge i_clk);
        if (o_busy !== 1'b0) begin n_errors++; test_done; end
        @(negedge i_clk);
    endtask
    task req(input [17:0] pgn);
        i_req_pgn = pgn;
        i_req_valid = 1;
        @(negedge i_clk);
        i_req_valid = 0;
        @(negedge i_clk);
    endtask
    function [63:0] exp_pl(input [11:0] c);
        exp_pl = 64'h0;
        for (int k = 0; k < 6; k++) exp_pl[63-8*k -: 8] = {3'h0, c[2*k], 3'h0, c[2*k+1]};
    endfunction
    // The second request lands while busy and must be dropped.
    task t_frame(input [7:0] a, input [11:0] c, input [1:0] m);
        s = n_starts;
        i_node_addr = a;
        i_ch_on = c;
        mode = m;
        repeat (3) @(negedge i_clk);
        req(18'h0_ff0f);
        req(18'h0_ff0f);
        wait_idle;
        `CHK("frm_id", {21'h18_ff0f, a}, o_frm_id)
        `CHK("dlc", 4'h8, o_frm_dlc)
        `CHK("payload", exp_pl(c), frame)
        `CHK("starts", s + 1, n_starts)
        `CHK("late", 1'b0, o_late)
        $display("frame test done");
    endtask
    task t_other;
        s = n_starts;
        req(18'h0_ff0e);
        repeat (20) @(negedge i_clk);
        `CHK("starts", s, n_starts)
        $display("other group test done");
    endtask
    // A stalled sink keeps the frame open past the shortened deadline.
    task t_late;
        mode = 2'h2;
        i_ch_on = 12'h5a3;
        repeat (3) @(negedge i_clk);
        req(18'h0_ff0f);
        repeat (60) @(negedge i_clk);
        `CHK("late", 1'b1, o_late)
        mode = 2'h0;
        wait_idle;
        `CHK("payload", exp_pl(12'h5a3), frame)
        $display("late test done");
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1;
        t_frame(8'ha0, 12'h0a5, 2'h0);
        t_frame(8'h01, 12'hf3c, 2'h1);
        t_late;
        t_other;
        t_frame(8'hfe, 12'hfff, 2'h0);
        test_done;
    end
endmodule // sscr_reporter_bench
